// ### verilog/encoder_pkg.sv
// shared constants and types for the dual encoder counter
package encoder_pkg;

  localparam int          DATA_W        = 32;           // apb data width
  localparam int          ADDR_W        = 8;            // apb address width
  localparam int          NUM_CHAN      = 2;            // channels a and b

  // byte offsets inside one channel window
  localparam logic [7:0]  REG_MODE_OFS   = 8'h00;       // direction and multiplication
  localparam logic [7:0]  REG_INDEX_OFS  = 8'h04;       // index clear arm and edge
  localparam logic [7:0]  REG_COUNT_OFS  = 8'h08;       // raw signed count, read only
  localparam logic [7:0]  REG_PRESET_OFS = 8'h0c;       // write loads the counter
  localparam logic [7:0]  REG_MULT_OFS   = 8'h10;       // scale multiplier
  localparam logic [7:0]  REG_OFFSET_OFS = 8'h14;       // scale offset
  localparam logic [7:0]  REG_SCALE_LO_OFS = 8'h18;     // scaled value low word
  localparam logic [7:0]  REG_SCALE_HI_OFS = 8'h1c;     // scaled value high word
  localparam logic [7:0]  CHAN_B_BASE    = 8'h40;       // channel b window
  localparam int          CHAN_SEL_BIT   = 6;           // address bit picking the channel
  localparam logic [7:0]  CHAN_WIN_MASK  = 8'h3f;       // offset bits inside a window

  // field positions
  localparam int          MODE_DIR_BIT   = 0;           // 1 = ccw counts up
  localparam int          MODE_MULT_LSB  = 1;           // two-bit multiplication code
  localparam int          IDX_ARM_BIT    = 0;           // 1 = index clear armed
  localparam int          IDX_FALL_BIT   = 1;           // 1 = falling edge clears

  // multiplication codes
  localparam logic [1:0]  MULT_1X        = 2'h0;
  localparam logic [1:0]  MULT_2X        = 2'h1;
  localparam logic [1:0]  MULT_4X        = 2'h2;

  // multiplier is fixed point with five fractional decimal digits
  localparam logic signed [31:0] SCALE_ONE    = 32'sh000186a0;  // 1.00000
  localparam logic signed [31:0] MULT_RESET   = 32'sh000186a0;  // unity gain
  localparam logic signed [31:0] OFFSET_RESET = 32'sh00000000;
  localparam logic [1:0]  MODE_MULT_RESET = 2'h2;       // 4x after reset
  localparam logic        MODE_DIR_RESET  = 1'b0;       // cw counts up after reset

  // per channel configuration held by the register file
  typedef struct packed {
    logic               dir_ccw;                        // count direction
    logic [1:0]         mult_sel;                       // edge multiplication
    logic               arm;                            // index clear armed
    logic               fall;                           // index edge select
    logic [31:0]        preset;                         // last preset written
    logic               load;                           // one-cycle preset strobe
    logic signed [31:0] mul;                            // multiplier, 1e-5 units
    logic signed [31:0] ofs;                            // offset, whole counts
    logic signed [63:0] scaled;                         // scaled value, 1e-5 units
    logic [31:0]        snap_hi;                        // high word caught on low read
  } chan_cfg_s;

endpackage : encoder_pkg

// ### verilog/quad_channel.sv
// one quadrature channel: pin sync, edge decode, counter, index clear
module quad_channel
  import encoder_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pha,          // phase a pin
  input  wire logic             phb,          // phase b pin
  input  wire logic             idx,          // index pin
  input  wire logic             dir_ccw,
  input  wire logic [1:0]       mult_sel,
  input  wire logic             arm,
  input  wire logic             fall,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] preset,
  output logic      [CNT_W-1:0] count
);

  // whole state of the channel
  typedef struct packed {
    logic [2:0]       s1;                     // first sync stage {idx,b,a}
    logic [2:0]       s2;                     // second sync stage
    logic [2:0]       prev;                   // s2 one cycle older
    logic [CNT_W-1:0] count;                  // signed running count
  } chan_state_s;

  chan_state_s state_reg;
  chan_state_s state_next;

  logic a_ed;                                 // phase a toggled
  logic b_ed;                                 // phase b toggled
  logic phase_xor;                            // a xor b after the edge
  logic step_en;                              // count this cycle
  logic fwd;                                  // motion is clockwise
  logic idx_hit;                              // selected index edge seen

  // decode edges and steer the counter
  always_comb
  begin
    state_next    = state_reg;
    state_next.s1 = {idx, phb, pha};
    state_next.s2 = state_reg.s1;
    state_next.prev = state_reg.s2;
    a_ed      = state_reg.s2[0] ^ state_reg.prev[0];
    b_ed      = state_reg.s2[1] ^ state_reg.prev[1];
    phase_xor = state_reg.s2[0] ^ state_reg.s2[1];
    // a edges lead forward when a differs from b, b edges when equal
    fwd       = a_ed ? phase_xor : ~phase_xor;
    case (mult_sel)
      MULT_1X: step_en = a_ed && !b_ed && state_reg.s2[0];
      MULT_2X: step_en = a_ed && !b_ed;
      MULT_4X: step_en = a_ed ^ b_ed;
      default: step_en = a_ed && !b_ed && state_reg.s2[0];
    endcase
    // index clear on the chosen edge while armed
    if (fall)
    begin
      idx_hit = state_reg.prev[2] && !state_reg.s2[2];
    end
    else
    begin
      idx_hit = !state_reg.prev[2] && state_reg.s2[2];
    end
    if (load)
    begin
      state_next.count = preset;
    end
    else if (arm && idx_hit)
    begin
      state_next.count = '0;
    end
    else if (step_en)
    begin
      // direction swap picks which rotation counts up
      if (fwd ^ dir_ccw)
      begin
        state_next.count = state_reg.count + CNT_W'(1);
      end
      else
      begin
        state_next.count = state_reg.count - CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;

endmodule : quad_channel

// ### verilog/dual_encoder_counter.sv
// apb register file, scaling and two quadrature channels
// Contract
// - per channel direction and 1x/2x/4x multiplication
// - index clear armed and cancelled per channel
// - armed index clears on chosen edge
// - armed state readable per channel
// - channel a count readable as signed
// - channel b count readable as signed
// - stored multiplier readable as signed fixed point
// - signed offset stored per channel
// - stored offset readable as signed
// - scaled value readable with fraction part
//
// Implementation choices: the APB slave port and the placing of the registers.
module dual_encoder_counter
  import encoder_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              chan_a_pha,
  input  wire logic              chan_a_phb,
  input  wire logic              chan_a_idx,
  input  wire logic              chan_b_pha,
  input  wire logic              chan_b_phb,
  input  wire logic              chan_b_idx
);

  // whole state of the register file
  typedef struct packed {
    chan_cfg_s [NUM_CHAN-1:0] ch;             // both channel configurations
    logic [DATA_W-1:0]        rdata;          // read data for the access phase
    logic                     slverr;         // error for the access phase
  } top_state_s;

  // the whole register file lives in one struct so that reset and
  // update stay in a single flop process
  top_state_s state_reg;
  top_state_s state_next;

  // channel side wiring
  logic [DATA_W-1:0] count_w [NUM_CHAN];      // live counts from the channels
  logic [NUM_CHAN-1:0] pha_w;                 // pin bundles per channel
  logic [NUM_CHAN-1:0] phb_w;
  logic [NUM_CHAN-1:0] idx_w;

  // decoded view of the current apb request
  logic              sel_ch;                  // addressed channel
  logic [7:0]        win_ofs;                 // offset inside the window
  logic              mapped;                  // address hits a register
  logic              setup_ph;                // apb setup cycle
  logic              access_ph;               // apb access cycle
  logic              wr_hit;                  // write takes effect now

  // merge write data into a word under byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    // start from the stored word, a cleared strobe keeps its byte
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // scaled value in 1e-5 units: count * multiplier + offset * one
  function automatic logic signed [63:0] scale_calc(input logic signed [31:0] cnt,
                                                    input logic signed [31:0] mul,
                                                    input logic signed [31:0] ofs);
    logic signed [63:0] c64;
    logic signed [63:0] m64;
    logic signed [63:0] o64;
    logic signed [63:0] one64;
    // sign extend all three operands before multiplying
    c64   = {{32{cnt[31]}}, cnt};
    m64   = {{32{mul[31]}}, mul};
    o64   = {{32{ofs[31]}}, ofs};
    one64 = {{32{SCALE_ONE[31]}}, SCALE_ONE};
    // both products are taken at 64 bits, so a full range count
    // times a full range multiplier cannot wrap
    return 64'(c64 * m64) + 64'(o64 * one64);
  endfunction : scale_calc

  // true when a window offset names a register
  function automatic logic ofs_valid(input logic [7:0] ofs);
    // one entry per listed word, everything else is refused
    case (ofs)
      REG_MODE_OFS, REG_INDEX_OFS, REG_COUNT_OFS, REG_PRESET_OFS,
      REG_MULT_OFS, REG_OFFSET_OFS, REG_SCALE_LO_OFS, REG_SCALE_HI_OFS:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction : ofs_valid

  // pin bundles for the channel instances
  // bit g of each bundle belongs to channel g
  assign pha_w = {chan_b_pha, chan_a_pha};
  assign phb_w = {chan_b_phb, chan_a_phb};
  assign idx_w = {chan_b_idx, chan_a_idx};

  // address decode
  always_comb
  begin
    // bit six picks the channel, the low six bits the word
    // anything with bit seven set, or an unlisted word, is unmapped
    sel_ch    = paddr[CHAN_SEL_BIT];
    win_ofs   = paddr & CHAN_WIN_MASK;
    mapped    = ((paddr & ~(CHAN_WIN_MASK | CHAN_B_BASE)) == 8'h00) && ofs_valid(win_ofs);
    // apb phases; pready is always high, so access lasts one cycle
    setup_ph  = psel && !penable;
    access_ph = psel && penable;
    wr_hit    = access_ph && pwrite && mapped;
  end

  // register file next state
  always_comb
  begin
    logic [DATA_W-1:0] rd;
    chan_cfg_s         c;
    // defaults: no read data, and the addressed channel's view
    rd         = '0;
    c          = state_reg.ch[sel_ch];
    state_next = state_reg;

    // preset strobes live one cycle only
    for (int k = 0; k < NUM_CHAN; k++)
    begin
      state_next.ch[k].load   = 1'b0;
      // keep a fresh scaled value for every channel
      state_next.ch[k].scaled = scale_calc(signed'(count_w[k]),
                                           state_reg.ch[k].mul,
                                           state_reg.ch[k].ofs);
    end

    // setup cycle: prepare read data and error for the access cycle
    if (setup_ph)
    begin
      // the error flag is decided here and shown in the access cycle,
      // so the access phase never waits
      state_next.slverr = !mapped;
      if (!pwrite && mapped)
      begin
        case (win_ofs)
          REG_MODE_OFS:
          begin
            rd[MODE_DIR_BIT]              = c.dir_ccw;
            rd[MODE_MULT_LSB +: 2]        = c.mult_sel;
          end
          REG_INDEX_OFS:
          begin
            rd[IDX_ARM_BIT]  = c.arm;
            rd[IDX_FALL_BIT] = c.fall;
          end
          REG_COUNT_OFS:
          begin
            // live count, two's complement
            rd = count_w[sel_ch];
          end
          REG_PRESET_OFS:
          begin
            rd = c.preset;
          end
          REG_MULT_OFS:
          begin
            rd = c.mul;
          end
          REG_OFFSET_OFS:
          begin
            rd = c.ofs;
          end
          REG_SCALE_LO_OFS:
          begin
            // low word read freezes the matching high word
            rd = c.scaled[31:0];
            state_next.ch[sel_ch].snap_hi = c.scaled[63:32];
          end
          REG_SCALE_HI_OFS:
          begin
            // high word as frozen by the last low word read; reading it
            // alone returns a stale half
            rd = c.snap_hi;
          end
          default:
          begin
            rd = '0;
          end
        endcase
      end
      // read data stands until the next setup cycle
      state_next.rdata = rd;
    end

    // access cycle: writes take effect on this edge
    // mode and index fields sit in byte 0, so only that strobe counts
    if (wr_hit)
    begin
      case (win_ofs)
        REG_MODE_OFS:
        begin
          if (pstrb[0])
          begin
            state_next.ch[sel_ch].dir_ccw  = pwdata[MODE_DIR_BIT];
            state_next.ch[sel_ch].mult_sel = pwdata[MODE_MULT_LSB +: 2];
          end
        end
        REG_INDEX_OFS:
        begin
          if (pstrb[0])
          begin
            // one writes arm, zero cancels
            state_next.ch[sel_ch].arm  = pwdata[IDX_ARM_BIT];
            state_next.ch[sel_ch].fall = pwdata[IDX_FALL_BIT];
          end
        end
        REG_PRESET_OFS:
        begin
          // the load strobe reaches the channel one cycle later, so the
          // count shows the new value on the first edge after this one
          state_next.ch[sel_ch].preset = apply_strb(c.preset, pwdata, pstrb);
          state_next.ch[sel_ch].load   = 1'b1;
        end
        REG_MULT_OFS:
        begin
          // value in units of 0.00001, i.e. sign ddd.ddddd times 1e5
          state_next.ch[sel_ch].mul = apply_strb(c.mul, pwdata, pstrb);
        end
        REG_OFFSET_OFS:
        begin
          // offset in whole counts, scaled by one unit when added
          state_next.ch[sel_ch].ofs = apply_strb(c.ofs, pwdata, pstrb);
        end
        default:
        begin
          // read-only words ignore writes
        end
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // everything clears, then the fields with nonzero reset values
      state_reg <= '0;
      for (int k = 0; k < NUM_CHAN; k++)
      begin
        state_reg.ch[k].dir_ccw  <= MODE_DIR_RESET;
        state_reg.ch[k].mult_sel <= MODE_MULT_RESET;
        state_reg.ch[k].mul      <= MULT_RESET;
        state_reg.ch[k].ofs      <= OFFSET_RESET;
      end
    end
    else
    begin
      // one copy of the whole state per clock
      state_reg <= state_next;
    end
  end

  // the two counting channels
  for (genvar g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    // each channel synchronises its own pins and owns its counter
    quad_channel #(
      .CNT_W    (DATA_W)
    ) u_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .pha      (pha_w[g]),
      .phb      (phb_w[g]),
      .idx      (idx_w[g]),
      .dir_ccw  (state_reg.ch[g].dir_ccw),
      .mult_sel (state_reg.ch[g].mult_sel),
      .arm      (state_reg.ch[g].arm),
      .fall     (state_reg.ch[g].fall),
      .load     (state_reg.ch[g].load),
      .preset   (state_reg.ch[g].preset),
      .count    (count_w[g])
    );
  end

  // zero wait state slave, data and error from flops
  // reads are prepared in the setup cycle, so no wait state is needed
  assign pready  = 1'b1;
  assign prdata  = state_reg.rdata;
  assign pslverr = state_reg.slverr && access_ph;

endmodule : dual_encoder_counter

// ### verification/dual_encoder_counter_asserts.sv
// apb checker for the dual encoder counter
module dual_encoder_counter_asserts
  import encoder_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] shadow_reg [2][8]; // expected readback per channel and word
  logic        ch;                // channel picked by the address
  logic [2:0]  wd;                // word inside the window
  logic        inwin;             // address inside a mapped window
  assign ch    = paddr[CHAN_SEL_BIT];
  assign wd    = paddr[4:2];
  assign inwin = !paddr[7] && !paddr[5] && (paddr[1:0] == 2'h0);
  // mirror of the writable words, reset to their reset values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < 2; c++)
      begin
        for (int w = 0; w < 8; w++)
        begin
          shadow_reg[c][w] <= (w == 0) ? {29'h0, MODE_MULT_RESET, MODE_DIR_RESET} :
                              (w == 4) ? MULT_RESET : 32'h0;
        end
      end
    end
    else if (psel && penable && pwrite && pready && inwin)
    begin
      // reserved bits of mode and index read back as zero
      shadow_reg[ch][wd] <= (wd == 3'h0) ? (pwdata & 32'h7) :
                            (wd == 3'h1) ? (pwdata & 32'h3) : pwdata;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup_bad;
    psel && !penable && paddr[7];
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_read(logic [2:0] w);
    psel && penable && !pwrite && inwin && (wd == w);
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (s_setup_bad ##1 s_access |-> pslverr)
    else $error("no error on unmapped access");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_err_zero_data: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("error read returned data");
  a_mapped_no_err: assert property (s_access ##0 inwin |-> !pslverr)
    else $error("error on mapped access");
  a_mode_readback: assert property (s_read(3'h0) |-> prdata == shadow_reg[ch][0])
    else $error("mode readback wrong");
  a_index_readback: assert property (s_read(3'h1) |-> prdata == shadow_reg[ch][1])
    else $error("index readback wrong");
  a_preset_readback: assert property (s_read(3'h3) |-> prdata == shadow_reg[ch][3])
    else $error("preset readback wrong");
  a_mult_readback: assert property (s_read(3'h4) |-> prdata == shadow_reg[ch][4])
    else $error("multiplier readback wrong");
  a_offset_readback: assert property (s_read(3'h5) |-> prdata == shadow_reg[ch][5])
    else $error("offset readback wrong");
endmodule : dual_encoder_counter_asserts

bind dual_encoder_counter dual_encoder_counter_asserts i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ### verification/quad_encoder_model.sv
// behavioural quadrature encoder with index pin
module quad_encoder_model
(
  input  wire logic pclk,
  output logic      pha,
  output logic      phb,
  output logic      idx
);
  timeunit 1ns;
  timeprecision 1ps;
  // encoder at rest with all lines low
  initial
  begin
    pha = 1'b0;
    phb = 1'b0;
    idx = 1'b0;
  end
  // whole quadrature cycles, a leads b when forward, two clocks per state
  task automatic move(input int n, input logic fwd);
    int k;
    for (int i = 0; i < n; i++)
    begin
      for (int j = 1; j <= 4; j++)
      begin
        k = fwd ? j % 4 : (4 - j) % 4;
        @(posedge pclk);
        pha <= (k == 1) || (k == 2);
        phb <= (k >= 2);
        @(posedge pclk);
      end
    end
    repeat (4) @(posedge pclk);
  endtask : move
  // index level change, then let the synchroniser settle
  task automatic zero(input logic v);
    @(posedge pclk);
    idx <= v;
    repeat (5) @(posedge pclk);
  endtask : zero
endmodule : quad_encoder_model

// ### verification/dual_encoder_counter_tb.sv
// self-checking bench for the dual encoder counter
module dual_encoder_counter_tb
  import encoder_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        a_pha, a_phb, a_idx, b_pha, b_phb, b_idx;
  logic [31:0] rd;          // last read data
  logic        err;         // last error flag
  int          mismatches;
  int          n_checks;
  int          cyc;
  dual_encoder_counter i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_a_pha(a_pha), .chan_a_phb(a_phb),
    .chan_a_idx(a_idx), .chan_b_pha(b_pha), .chan_b_phb(b_phb), .chan_b_idx(b_idx));
  quad_encoder_model i_enc_a (.pclk(pclk), .pha(a_pha), .phb(a_phb), .idx(a_idx));
  quad_encoder_model i_enc_b (.pclk(pclk), .pha(b_pha), .phb(b_phb), .idx(b_idx));
  always #5 pclk = ~pclk;
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  function automatic logic [7:0] bs(input int ch);
    return (ch == 1) ? CHAN_B_BASE : 8'h00;
  endfunction : bs
  task automatic mv(input int ch, input int n, input logic fwd);
    if (ch == 1) i_enc_b.move(n, fwd);
    else i_enc_a.move(n, fwd);
  endtask : mv
  task automatic zi(input int ch, input logic v);
    if (ch == 1) i_enc_b.zero(v);
    else i_enc_a.zero(v);
  endtask : zi
  // reset values of every channel
  task automatic t_reset();
    for (int c = 0; c < 2; c++)
    begin
      rdchk(bs(c) + REG_MODE_OFS, 32'h4);
      rdchk(bs(c) + REG_INDEX_OFS, 32'h0);
      rdchk(bs(c) + REG_MULT_OFS, MULT_RESET);
      rdchk(bs(c) + REG_OFFSET_OFS, 32'h0);
      rdchk(bs(c) + REG_COUNT_OFS, 32'h0);
    end
    $display("test reset done");
  endtask : t_reset
  // every direction and multiplication, net two cycles forward
  task automatic t_modes();
    logic [1:0] code [4];
    int         f;
    code = '{MULT_1X, MULT_2X, MULT_4X, 2'h3};
    for (int c = 0; c < 2; c++)
      for (int d = 0; d < 2; d++)
        for (int m = 0; m < 4; m++)
        begin
          // code 3 is not a listed multiplication and counts as 1x
          f = (m == 1) ? 4 : (m == 2) ? 8 : 2;
          apb(1'b1, bs(c) + REG_MODE_OFS, {29'h0, code[m], d[0]});
          rdchk(bs(c) + REG_MODE_OFS, {29'h0, code[m], d[0]});
          apb(1'b1, bs(c) + REG_PRESET_OFS, -32'sd100);
          mv(c, 3, 1'b1);
          mv(c, 1, 1'b0);
          rdchk(bs(c) + REG_COUNT_OFS, -100 + ((d == 1) ? -f : f));
          rdchk(bs(c) + REG_PRESET_OFS, -32'sd100);
        end
    $display("test modes done");
  endtask : t_modes
  // index clear on each edge, then cancelled
  task automatic t_index();
    for (int c = 0; c < 2; c++)
    begin
      for (int fe = 0; fe < 2; fe++)
      begin
        apb(1'b1, bs(c) + REG_INDEX_OFS, {30'h0, fe[0], 1'b1});
        rdchk(bs(c) + REG_INDEX_OFS, {30'h0, fe[0], 1'b1});
        apb(1'b1, bs(c) + REG_PRESET_OFS, 32'd1000);
        zi(c, 1'b1);
        rdchk(bs(c) + REG_COUNT_OFS, (fe == 1) ? 32'd1000 : 32'd0);
        apb(1'b1, bs(c) + REG_PRESET_OFS, 32'd1000);
        zi(c, 1'b0);
        rdchk(bs(c) + REG_COUNT_OFS, (fe == 1) ? 32'd0 : 32'd1000);
      end
      apb(1'b1, bs(c) + REG_INDEX_OFS, 32'h0);
      rdchk(bs(c) + REG_INDEX_OFS, 32'h0);
      apb(1'b1, bs(c) + REG_PRESET_OFS, 32'd1000);
      zi(c, 1'b1);
      zi(c, 1'b0);
      rdchk(bs(c) + REG_COUNT_OFS, 32'd1000);
    end
    $display("test index done");
  endtask : t_index
  // scaled value from count, multiplier and offset
  task automatic t_scale();
    logic signed [31:0] mul, ofs, cnt;
    longint             e;
    for (int c = 0; c < 2; c++)
    begin
      mul = (c == 1) ? 32'sd12345678 : -32'sd250000; // 123.45678 and -2.50000
      ofs = (c == 1) ? -32'sd3 : 32'sd7;
      cnt = (c == 1) ? 32'sd100000 : 32'sd40;
      e = longint'(cnt) * longint'(mul) + longint'(ofs) * 100000;
      apb(1'b1, bs(c) + REG_MULT_OFS, mul);
      apb(1'b1, bs(c) + REG_OFFSET_OFS, ofs);
      apb(1'b1, bs(c) + REG_PRESET_OFS, cnt);
      rdchk(bs(c) + REG_MULT_OFS, mul);
      rdchk(bs(c) + REG_OFFSET_OFS, ofs);
      rdchk(bs(c) + REG_SCALE_LO_OFS, e[31:0]);
      rdchk(bs(c) + REG_SCALE_HI_OFS, e[63:32]);
    end
    $display("test scale done");
  endtask : t_scale
  // unmapped reads and a write to the read-only count
  task automatic t_errors();
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h60, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, REG_COUNT_OFS, 32'h5);
    rdchk(REG_COUNT_OFS, 32'd40);
    $display("test errors done");
  endtask : t_errors
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 8'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_index();
    t_scale();
    t_errors();
    end_sim();
  end
endmodule : dual_encoder_counter_tb
